// ---- verilog/udt_params.svh ----
// Constants for the up/down reload timer: offsets, fields, resets.
// Assumes an 8-bit register port with a 16-bit byte address.
`ifndef UDT_PARAMS_SVH
`define UDT_PARAMS_SVH

// Register addresses
`define UDT_ADDR_MODE       16'hFFC4
`define UDT_ADDR_COUNT      16'hFFC5
`define UDT_ADDR_IRQ_CTL    16'hFFC8

// Mode register fields
`define UDT_MODE_RELOAD_BIT 7
`define UDT_MODE_DSRC_BIT   6
`define UDT_MODE_SWDIR_BIT  5
`define UDT_MODE_CSEL_HI    2
`define UDT_MODE_CSEL_LO    0
`define UDT_MODE_FIXED_ONES 8'h18
`define UDT_MODE_WR_MASK    8'hE7
`define UDT_MODE_RESET      8'h18

// Interrupt control register fields
`define UDT_IRQ_FLAG_BIT    0
`define UDT_IRQ_EN_BIT      1
`define UDT_IRQ_EDGE_BIT    2

// Count and reload resets, wrap values
`define UDT_COUNT_RESET     8'h00
`define UDT_RELOAD_RESET    8'h00
`define UDT_COUNT_MAX       8'hFF
`define UDT_COUNT_MIN       8'h00

// Prescaler width and divider tap widths (divide by 2**w)
`define UDT_PRESC_W         13
`define UDT_TAP_8192        13
`define UDT_TAP_2048        11
`define UDT_TAP_512         9
`define UDT_TAP_256         8
`define UDT_TAP_128         7
`define UDT_TAP_32          5
`define UDT_TAP_8           3

// Cycles after reset before an event edge may count
`define UDT_EDGE_ARM_W      3

`endif

// ---- verilog/udt_pkg.sv ----
// Types for the up/down reload timer.
// Assumes the constants header is compiled alongside.
package udt_pkg;

    // Clock-select codes of the mode register
    typedef enum logic [2:0] {
        UDT_CS_DIV8192 = 3'h0,
        UDT_CS_DIV2048 = 3'h1,
        UDT_CS_DIV512  = 3'h2,
        UDT_CS_DIV256  = 3'h3,
        UDT_CS_DIV128  = 3'h4,
        UDT_CS_DIV32   = 3'h5,
        UDT_CS_DIV8    = 3'h6,
        UDT_CS_EXT     = 3'h7
    } udt_csel_e;

    // Counting direction
    typedef enum logic {
        UDT_DIR_UP   = 1'h0,
        UDT_DIR_DOWN = 1'h1
    } udt_dir_e;

endpackage

// ---- verilog/udt_timer.sv ----
// Eight-bit up/down interval and auto-reload timer with register port.
// Assumes a single 125 MHz clock, synchronous active-low reset,
// and asynchronous event and direction pins.
// A reload write in a tick cycle swallows that tick, with no flag.
//
// How it works
// - 8-bit up/down counter, interval or reload mode
// - Seven prescaled internal clocks plus external events
// - Clock-select codes 000..110 dividers, 111 external
// - Edge-select bit picks rising or falling events
// - Mode bit 7: interval 0, reload 1
// - Software direction bit: 0 up, 1 down
// - Direction source 1: pin high counts down
// - Mode bits 4 and 3 read one
// - Counter readable anytime without disturbing count
// - Overflow or underflow sets timer request flag
// - Counter read and reload write share address
// - Reload write also loads the counter
// - Reload mode reloads counter on wrap
// - Mode register resets to 0x18
// - Counter and reload reset to zero
// - Flag and enable together request interrupt
`timescale 1ns/1ns
`include "udt_params.svh"

module udt_timer (
    input  wire logic       MCLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic [15:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    input  wire logic       EVENT_INPUT_PIN_IN,
    input  wire logic       DIRECTION_INPUT_PIN_IN,
    output logic      [7:0] RDATA_OUT,
    output logic            IRQ_OUT
);

    // Picks the prescaler tap for a clock-select code
    function automatic logic tap_tick(
        input logic [2:0]                csel,
        input logic [`UDT_PRESC_W-1:0]   presc,
        input logic                      ext_edge
    );
        logic t;
        t = 1'b0;
        case (udt_pkg::udt_csel_e'(csel))
            udt_pkg::UDT_CS_DIV8192: t = &presc[`UDT_TAP_8192-1:0];
            udt_pkg::UDT_CS_DIV2048: t = &presc[`UDT_TAP_2048-1:0];
            udt_pkg::UDT_CS_DIV512:  t = &presc[`UDT_TAP_512-1:0];
            udt_pkg::UDT_CS_DIV256:  t = &presc[`UDT_TAP_256-1:0];
            udt_pkg::UDT_CS_DIV128:  t = &presc[`UDT_TAP_128-1:0];
            udt_pkg::UDT_CS_DIV32:   t = &presc[`UDT_TAP_32-1:0];
            udt_pkg::UDT_CS_DIV8:    t = &presc[`UDT_TAP_8-1:0];
            udt_pkg::UDT_CS_EXT:     t = ext_edge;
            default:                 t = 1'b0;
        endcase
        return t;
    endfunction

    // Register-port decode, shared by write and read paths
    function automatic logic addr_hit(
        input logic [15:0] addr,
        input logic [15:0] target
    );
        return addr == target;
    endfunction

    // Pin synchronisers: bit 0 event pin, bit 1 direction pin
    logic [1:0] pin_raw;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic       event_prev_q;

    assign pin_raw = {DIRECTION_INPUT_PIN_IN, EVENT_INPUT_PIN_IN};

    // Two flops per pin before any logic looks at it
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            always_ff @(posedge MCLK_IN) begin
                if (!RST_N_IN) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Edge detector state: last level and a reset warm-up
    logic                       event_prev_d;
    logic [`UDT_EDGE_ARM_W-1:0] edge_arm_q;
    logic [`UDT_EDGE_ARM_W-1:0] edge_arm_d;

    // Warm-up hides the step from reset level to a high idle pin
    always_comb begin
        event_prev_d = sync2_q[0];
        edge_arm_d   = {edge_arm_q[`UDT_EDGE_ARM_W-2:0], 1'b1};
    end

    // Edge detector registers
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            event_prev_q <= 1'b0;
            edge_arm_q   <= '0;
        end else begin
            event_prev_q <= event_prev_d;
            edge_arm_q   <= edge_arm_d;
        end
    end

    // Register state
    logic [7:0]              mode_q;
    logic [7:0]              mode_d;
    logic [7:0]              count_q;
    logic [7:0]              count_d;
    logic [7:0]              reload_q;
    logic [7:0]              reload_d;
    logic                    flag_q;
    logic                    flag_d;
    logic                    irq_en_q;
    logic                    irq_en_d;
    logic                    edge_sel_q;
    logic                    edge_sel_d;
    logic [`UDT_PRESC_W-1:0] presc_q;
    logic [`UDT_PRESC_W-1:0] presc_d;
    logic [7:0]              rdata_q;
    logic [7:0]              rdata_d;
    logic                    irq_q;
    logic                    irq_d;

    // Decoded strobes
    logic wr_mode;
    logic wr_count;
    logic wr_irq;
    logic wr_clear;

    assign wr_mode  = WR_IN && addr_hit(ADDR_IN, `UDT_ADDR_MODE);
    assign wr_count = WR_IN && addr_hit(ADDR_IN, `UDT_ADDR_COUNT);
    assign wr_irq   = WR_IN && addr_hit(ADDR_IN, `UDT_ADDR_IRQ_CTL);
    assign wr_clear = wr_irq && !WDATA_IN[`UDT_IRQ_FLAG_BIT];

    // Counting clock selection and direction
    logic                 ext_edge;
    logic                 tick;
    udt_pkg::udt_dir_e    dir;
    logic                 wrap;
    logic [7:0]           wrap_val;

    // Rising edge when select is 1, falling when 0
    assign ext_edge = edge_arm_q[`UDT_EDGE_ARM_W-1]
                   && (edge_sel_q ? (sync2_q[0] && !event_prev_q)
                                  : (!sync2_q[0] && event_prev_q));

    // Tick from prescaler tap or event edge
    assign tick = tap_tick(mode_q[`UDT_MODE_CSEL_HI:`UDT_MODE_CSEL_LO],
                           presc_q, ext_edge);

    // A reload write swallows a coincident tick
    logic count_tick;
    assign count_tick = tick && !wr_count;

    // Pin steers direction when source bit set, else software bit
    always_comb begin
        if (mode_q[`UDT_MODE_DSRC_BIT]) begin
            dir = udt_pkg::udt_dir_e'(sync2_q[1]);
        end else begin
            dir = udt_pkg::udt_dir_e'(mode_q[`UDT_MODE_SWDIR_BIT]);
        end
    end

    // Wrap detection at the end of range in the counting direction
    always_comb begin
        if (dir == udt_pkg::UDT_DIR_DOWN) begin
            wrap     = count_q == `UDT_COUNT_MIN;
            wrap_val = `UDT_COUNT_MAX;
        end else begin
            wrap     = count_q == `UDT_COUNT_MAX;
            wrap_val = `UDT_COUNT_MIN;
        end
    end

    // Free-running prescaler next value
    always_comb begin
        presc_d = presc_q + `UDT_PRESC_W'(1);
    end

    // Prescaler register
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_d;
        end
    end

    // Mode, reload and interrupt control next values
    always_comb begin
        mode_d     = mode_q;
        reload_d   = reload_q;
        irq_en_d   = irq_en_q;
        edge_sel_d = edge_sel_q;
        if (wr_mode) begin
            mode_d = (WDATA_IN & `UDT_MODE_WR_MASK)
                   | `UDT_MODE_FIXED_ONES;
        end
        if (wr_count) begin
            reload_d = WDATA_IN;
        end
        if (wr_irq) begin
            irq_en_d   = WDATA_IN[`UDT_IRQ_EN_BIT];
            edge_sel_d = WDATA_IN[`UDT_IRQ_EDGE_BIT];
        end
    end

    // Counter next value: reload write beats a tick
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = WDATA_IN;
        end else if (tick) begin
            if (wrap) begin
                if (mode_q[`UDT_MODE_RELOAD_BIT]) begin
                    count_d = reload_q;
                end else begin
                    count_d = wrap_val;
                end
            end else if (dir == udt_pkg::UDT_DIR_DOWN) begin
                count_d = count_q - 8'h01;
            end else begin
                count_d = count_q + 8'h01;
            end
        end
    end

    // Request flag: a wrap in the clearing cycle wins
    always_comb begin
        flag_d = flag_q;
        if (wr_clear) begin
            flag_d = 1'b0;
        end
        if (count_tick && wrap) begin
            flag_d = 1'b1;
        end
    end

    // Request output: flag gated by its enable
    always_comb begin
        irq_d = flag_d && irq_en_d;
    end

    // Read data for the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = 8'h00;
        if (RD_IN) begin
            if (addr_hit(ADDR_IN, `UDT_ADDR_MODE)) begin
                rdata_d = mode_q | `UDT_MODE_FIXED_ONES;
            end else if (addr_hit(ADDR_IN, `UDT_ADDR_COUNT)) begin
                rdata_d = count_q;
            end else if (addr_hit(ADDR_IN, `UDT_ADDR_IRQ_CTL)) begin
                rdata_d = {5'h00, edge_sel_q, irq_en_q, flag_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Register updates
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            mode_q     <= `UDT_MODE_RESET;
            count_q    <= `UDT_COUNT_RESET;
            reload_q   <= `UDT_RELOAD_RESET;
            flag_q     <= 1'b0;
            irq_en_q   <= 1'b0;
            edge_sel_q <= 1'b0;
            rdata_q    <= 8'h00;
            irq_q      <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            count_q    <= count_d;
            reload_q   <= reload_d;
            flag_q     <= flag_d;
            irq_en_q   <= irq_en_d;
            edge_sel_q <= edge_sel_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
        end
    end

    // Outputs straight from flops
    assign RDATA_OUT = rdata_q;
    assign IRQ_OUT   = irq_q;

endmodule // udt_timer

// ---- sim/udt_timer_properties.sv ----
// Checker for the timer's register port and request output.
// Assumes it is bound to udt_timer and sees only its ports.
`timescale 1ns/1ns
`include "udt_params.svh"

module udt_timer_chk (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic [15:0] ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    input  wire logic [7:0]  RDATA_OUT,
    input  wire logic        IRQ_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // Single register accesses
    sequence wr_s(a); WR_IN && ADDR_IN == a; endsequence
    sequence rd_s(a); RD_IN && ADDR_IN == a; endsequence

    rd_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data not idle");
    fixed_ones_a: assert property (rd_s(`UDT_ADDR_MODE) |=> RDATA_OUT[4:3] == 2'b11)
        else $error("mode bits 4 and 3 not one");
    mode_rback_a: assert property (wr_s(`UDT_ADDR_MODE) ##1 rd_s(`UDT_ADDR_MODE) |=>
        RDATA_OUT == (($past(WDATA_IN, 2) & `UDT_MODE_WR_MASK) | `UDT_MODE_FIXED_ONES))
        else $error("mode readback wrong");
    count_load_a: assert property (wr_s(`UDT_ADDR_COUNT) ##1 rd_s(`UDT_ADDR_COUNT) |=>
        RDATA_OUT == $past(WDATA_IN, 2)) else $error("reload did not load count");
    ctl_rback_a: assert property (wr_s(`UDT_ADDR_IRQ_CTL) ##1 rd_s(`UDT_ADDR_IRQ_CTL) |=>
        RDATA_OUT[2:1] == $past(WDATA_IN[2:1], 2)) else $error("control readback wrong");
    unmapped_rd_a: assert property (RD_IN && !(ADDR_IN inside {`UDT_ADDR_MODE,
        `UDT_ADDR_COUNT, `UDT_ADDR_IRQ_CTL}) |=> RDATA_OUT == 8'h00) else $error("unmapped read");
    irq_hold_a: assert property (IRQ_OUT && !(WR_IN && ADDR_IN == `UDT_ADDR_IRQ_CTL)
        |=> IRQ_OUT) else $error("request dropped");
    irq_off_a: assert property (WR_IN && ADDR_IN == `UDT_ADDR_IRQ_CTL && !WDATA_IN[1]
        |=> !IRQ_OUT) else $error("request not masked");
endmodule // udt_timer_chk

bind udt_timer udt_timer_chk chk_u (.MCLK_IN, .RST_N_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN,
    .RDATA_OUT, .IRQ_OUT);

// ---- sim/udt_testbench.sv ----
// Self-checking bench for the up/down reload timer.
// Assumes the checker file is compiled before it.
`timescale 1ns/1ns
`include "udt_params.svh"

module testbench;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr  = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        ev    = 1'b0;
    logic        dir   = 1'b0;
    logic [7:0]  rdata;
    logic        irq;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          n;
    // Divider per clock-select code
    int          div [7]    = '{8192, 2048, 512, 256, 128, 32, 8};
    // Event rows: control, mode, pin direction, pin level, request, count
    logic [26:0] evt [9]    = '{{8'h06, 8'h47, 3'b110, 8'h00}, {8'h06, 8'h47, 3'b100, 8'h00},
        {8'h06, 8'h47, 3'b111, 8'hFF}, {8'h06, 8'h47, 3'b000, 8'hFF},
        {8'h06, 8'h47, 3'b011, 8'h00}, {8'h06, 8'h67, 3'b000, 8'h00},
        {8'h06, 8'h67, 3'b010, 8'h01}, {8'h02, 8'h27, 3'b100, 8'h00},
        {8'h02, 8'h27, 3'b110, 8'h00}};

    // System clock, 8 ns period
    always #4 clk = ~clk;

    udt_timer dut_u (
        .MCLK_IN                (clk),
        .RST_N_IN               (rst_n),
        .ADDR_IN                (addr),
        .WDATA_IN               (wdata),
        .WR_IN                  (wr),
        .RD_IN                  (rd),
        .EVENT_INPUT_PIN_IN     (ev),
        .DIRECTION_INPUT_PIN_IN (dir),
        .RDATA_OUT              (rdata),
        .IRQ_OUT                (irq)
    );

    // Counts and verdict
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare one result
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus cycle driven at the rising edge
    task op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
    endtask

    task w(input logic [15:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
    endtask

    // Read and compare the data of the following cycle
    task rdc(input logic [15:0] a, input logic [7:0] e, input string nm);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        @(negedge clk);
        chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask

    // Bounded wait for the request, n counts cycles
    task wirq(input int lim);
        n = 0;
        op(1'b0, 1'b0, 16'h0000, 8'h00);
        @(negedge clk);
        while (irq !== 1'b1) begin
            n++;
            if (n > lim) begin
                chk("request wait", 16'h0001, {15'h0000, irq});
                end_sim;
            end
            @(negedge clk);
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`UDT_ADDR_MODE, 8'h18, "mode");
        rdc(`UDT_ADDR_COUNT, 8'h00, "count");
        w(`UDT_ADDR_MODE, 8'hFF);
        rdc(`UDT_ADDR_MODE, 8'hFF, "mode");
        w(`UDT_ADDR_MODE, 8'h00);
        rdc(`UDT_ADDR_MODE, 8'h18, "mode");
        w(16'hFFC6, 8'hAA);
        rdc(16'hFFC6, 8'h00, "unmapped");
        w(`UDT_ADDR_IRQ_CTL, 8'h06);
        rdc(`UDT_ADDR_IRQ_CTL, 8'h06, "control");
        w(`UDT_ADDR_COUNT, 8'h01);
        rdc(`UDT_ADDR_COUNT, 8'h01, "count");
        foreach (evt[i]) begin
            w(`UDT_ADDR_IRQ_CTL, evt[i][26:19]);
            dir <= evt[i][10];
            w(`UDT_ADDR_MODE, evt[i][18:11]);
            op(1'b0, 1'b0, 16'h0000, 8'h00);
            ev <= evt[i][9];
            repeat (6) @(posedge clk);
            @(negedge clk);
            chk("request", {15'h0000, evt[i][8]}, {15'h0000, irq});
            rdc(`UDT_ADDR_COUNT, evt[i][7:0], "count");
        end
        for (int c = 0; c < 7; c++) begin
            w(`UDT_ADDR_MODE, 8'h80 | 8'(c));
            w(`UDT_ADDR_COUNT, 8'hFF);
            rdc(`UDT_ADDR_COUNT, 8'hFF, "count");
            wirq(2 * div[c] + 8);
            w(`UDT_ADDR_IRQ_CTL, 8'h02);
            wirq(div[c] + 8);
            w(`UDT_ADDR_IRQ_CTL, 8'h02);
            wirq(div[c] + 8);
            chk("period", 16'(div[c] - 2), 16'(n));
        end
        w(`UDT_ADDR_IRQ_CTL, 8'h00);
        op(1'b0, 1'b0, 16'h0000, 8'h00);
        @(negedge clk);
        chk("request", 16'h0000, {15'h0000, irq});
        end_sim;
    end
endmodule // testbench
